//--- otp_startup_sequencer.v
// Fuse-to-shadow loader, shadow-to-live copier and regulator start-up sequencer.
`timescale 1ns/10ps
`include "otp_defs.vh"
module otp_startup_sequencer #(
	parameter TICK_DIV = `TICK_DIV,
	parameter OFF_HOLD_TICKS = `OFF_HOLD_TICKS
) (
	input wire core_clk,
	input wire reset_n,
	input wire vin_above_threshold,
	input wire power_on_in,
	input wire trial_start,
	input wire [`SH_W-1:0] fuse_image,
	input wire shadow_wr_en,
	input wire [`SH_W-1:0] shadow_wr_data,
	input wire live_volt_wr_en,
	input wire [`SH_VOLT_W-1:0] live_volt_wr_data,
	input wire live_en_wr_en,
	input wire [`NUM_REG-1:0] live_en_wr_data,
	input wire addr_cfg_wr_en,
	input wire [7:0] addr_cfg_wr_data,
	input wire addr_cfg_wr_done,
	output wire [`SH_W-1:0] shadow_config_regs,
	output wire [`SH_VOLT_W-1:0] live_buck1_voltage,
	output wire [`NUM_REG-1:0] reg_enable,
	output wire buck_ramp_step,
	output wire power_good_reset_n,
	output wire sequence_done,
	output wire device_on,
	output wire cold_loaded,
	output wire [7:0] bus_address_config,
	output wire [6:0] bus_target_address
);
	// --------------------------------------------------------------------
	// States
	// --------------------------------------------------------------------
	localparam [5:0] ST_OFF = 6'h01;
	localparam [5:0] ST_LOAD = 6'h02;
	localparam [5:0] ST_COPY = 6'h04;
	localparam [5:0] ST_SEQ = 6'h08;
	localparam [5:0] ST_PGWAIT = 6'h10;
	localparam [5:0] ST_ON = 6'h20;

	localparam integer RAMP_FAST_I = `RAMP_FAST_CYC;
	localparam integer RAMP_SLOW_I = `RAMP_SLOW_CYC;
	localparam integer SLOT_SHORT_I = `SLOT_SHORT_TICKS;
	localparam integer SLOT_LONG_I = `SLOT_LONG_TICKS;
	localparam [12:0] TICK_PERIOD = TICK_DIV[12:0];
	localparam [9:0] RAMP_FAST = RAMP_FAST_I[9:0];
	localparam [9:0] RAMP_SLOW = RAMP_SLOW_I[9:0];
	localparam [6:0] SLOT_SHORT = SLOT_SHORT_I[6:0];
	localparam [6:0] SLOT_LONG = SLOT_LONG_I[6:0];

	reg [5:0] state_ff;
	reg [5:0] nxt_state;
	reg [`SH_W-1:0] shadow_ff;
	reg cold_loaded_ff;
	reg [`SH_VOLT_W-1:0] volt_ff;
	reg ramp_sel_ff;
	reg [`NUM_REG-1:0] enable_ff;
	reg [3:0] slot_ff;
	reg [3:0] last_slot_ff;
	reg [6:0] tick_cnt_ff;
	reg pg_ff;
	reg [7:0] addr_cfg_ff;
	reg [7:0] addr_pend_ff;
	reg pend_ff;
	reg [3:0] max_slot;
	reg [6:0] slot_ticks;
	reg tb_clear;
	integer i;
	integer j;

	wire tick32;
	wire turn_on_req;
	wire turn_off_req;
	wire slot_edge;

	// --------------------------------------------------------------------
	// Functions
	// --------------------------------------------------------------------
	// Returns regulator idx's slot code, widened to four bits.
	function [3:0] slot_code;
		input [`SH_W-1:0] img;
		input integer idx;
		begin
			if (idx < `NUM_SEQ3)
				slot_code = {1'b0, img[`SH_SEQ3_LSB + 3 * idx +: 3]};
			else
				slot_code = img[`SH_SEQ4_LSB + 4 * (idx - `NUM_SEQ3) +: 4];
		end
	endfunction

	// --------------------------------------------------------------------
	// Timebases
	// --------------------------------------------------------------------
	// The slow tick is restarted at the turn-on event so slot 1 is a whole
	// period away from it rather than a random fraction.
	always @* begin
		tb_clear = (state_ff == ST_COPY);
	end

	tick_divider #(.W(13)) u_slow_tick (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clear(tb_clear),
		.period(TICK_PERIOD),
		.tick_ff(tick32)
	);

	// The ramp step runs continuously; the regulator consumes it only while ramping.
	tick_divider #(.W(10)) u_ramp_tick (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clear(1'b0),
		.period(ramp_sel_ff ? RAMP_SLOW : RAMP_FAST),
		.tick_ff(buck_ramp_step)
	);

	power_on_detect #(.HOLD_W(17), .HOLD_TICKS(OFF_HOLD_TICKS)) u_pwr_on (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.power_on_in(power_on_in),
		.sense_edge(shadow_ff[`SH_SENSE_BIT]),
		.tick32(tick32),
		.turn_on_ff(turn_on_req),
		.turn_off_ff(turn_off_req)
	);

	// --------------------------------------------------------------------
	// Sequence arithmetic
	// --------------------------------------------------------------------
	// Highest used slot and period length, both taken from the shadow image.
	always @* begin
		max_slot = 4'h0;
		for (i = 0; i < `NUM_REG; i = i + 1) begin
			if (slot_code(shadow_ff, i) > max_slot)
				max_slot = slot_code(shadow_ff, i);
		end
		if (shadow_ff[`SH_PERIOD_BIT])
			slot_ticks = SLOT_LONG;
		else
			slot_ticks = SLOT_SHORT;
	end

	assign slot_edge = tick32 && (tick_cnt_ff == slot_ticks - 7'h01);

	// --------------------------------------------------------------------
	// State machine
	// --------------------------------------------------------------------
	// A turn-off request wins over everything except the idle state itself.
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OFF: begin
				if (cold_loaded_ff && vin_above_threshold) begin
					if (trial_start)
						nxt_state = ST_COPY;
					else if (turn_on_req)
						nxt_state = ST_LOAD;
				end
			end
			ST_LOAD: nxt_state = ST_COPY;
			ST_COPY: nxt_state = (max_slot == 4'h0) ? ST_PGWAIT : ST_SEQ;
			ST_SEQ: begin
				if (slot_edge && slot_ff + 4'h1 == last_slot_ff)
					nxt_state = ST_PGWAIT;
			end
			ST_PGWAIT: begin
				if (tick32 && tick_cnt_ff == `PG_DELAY_TICKS - 1)
					nxt_state = ST_ON;
			end
			ST_ON: nxt_state = ST_ON;
			default: nxt_state = ST_OFF;
		endcase
		if (turn_off_req && state_ff != ST_OFF)
			nxt_state = ST_OFF;
	end

	// --------------------------------------------------------------------
	// Sequencer registers
	// --------------------------------------------------------------------
	// Slot counter, tick counter, live enables and the power-good output.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			state_ff <= ST_OFF;
			slot_ff <= 4'h0;
			last_slot_ff <= 4'h0;
			tick_cnt_ff <= 7'h00;
			enable_ff <= {`NUM_REG{1'b0}};
			pg_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (nxt_state == ST_OFF) begin
				enable_ff <= {`NUM_REG{1'b0}};
				pg_ff <= 1'b0;
				slot_ff <= 4'h0;
				tick_cnt_ff <= 7'h00;
			end else begin
				case (state_ff)
					ST_COPY: begin
						slot_ff <= 4'h0;
						tick_cnt_ff <= 7'h00;
						enable_ff <= {`NUM_REG{1'b0}};
					end
					ST_SEQ: begin
						if (slot_edge) begin
							tick_cnt_ff <= 7'h00;
							slot_ff <= slot_ff + 4'h1;
							for (j = 0; j < `NUM_REG; j = j + 1) begin
								if (slot_code(shadow_ff, j) == slot_ff + 4'h1)
									enable_ff[j] <= 1'b1;
							end
						end else if (tick32) begin
							tick_cnt_ff <= tick_cnt_ff + 7'h01;
						end
						if (nxt_state == ST_PGWAIT)
							tick_cnt_ff <= 7'h00;
					end
					ST_PGWAIT: begin
						if (tick32)
							tick_cnt_ff <= tick_cnt_ff + 7'h01;
						if (nxt_state == ST_ON)
							pg_ff <= 1'b1;
					end
					ST_ON: begin
						if (live_en_wr_en)
							enable_ff <= live_en_wr_data;
					end
					default: begin
						tick_cnt_ff <= tick_cnt_ff;
					end
				endcase
			end
			// The end slot is frozen at copy time so later shadow writes
			// cannot add or drop slots of a running sequence.
			if (state_ff == ST_COPY)
				last_slot_ff <= max_slot;
		end
	end

	// --------------------------------------------------------------------
	// Shadow and live configuration
	// --------------------------------------------------------------------
	// Shadow writes only change the image; voltage and ramp outputs follow the live copies.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			shadow_ff <= {`SH_W{1'b0}};
			cold_loaded_ff <= 1'b0;
			volt_ff <= {`SH_VOLT_W{1'b0}};
			ramp_sel_ff <= 1'b0;
		end else begin
			if (!cold_loaded_ff && vin_above_threshold) begin
				shadow_ff <= fuse_image;
				cold_loaded_ff <= 1'b1;
			end else if (state_ff == ST_LOAD) begin
				shadow_ff <= fuse_image;
			end else if (shadow_wr_en) begin
				shadow_ff <= shadow_wr_data;
			end
			if (state_ff == ST_COPY) begin
				volt_ff <= shadow_ff[`SH_VOLT_LSB +: `SH_VOLT_W];
				ramp_sel_ff <= shadow_ff[`SH_RAMP_BIT];
			end else if (live_volt_wr_en) begin
				volt_ff <= live_volt_wr_data;
			end
		end
	end

	// --------------------------------------------------------------------
	// Bus target address
	// --------------------------------------------------------------------
	// A write is held pending and only applied on completion, so the
	// transaction that changes the address still finishes at the old one.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			addr_cfg_ff <= `ADDR_RESET;
			addr_pend_ff <= `ADDR_RESET;
			pend_ff <= 1'b0;
		end else begin
			if (addr_cfg_wr_en) begin
				addr_pend_ff <= addr_cfg_wr_data;
				pend_ff <= 1'b1;
			end
			if (state_ff == ST_LOAD || (!cold_loaded_ff && vin_above_threshold)) begin
				addr_cfg_ff <= {fuse_image[`SH_USE_DEF_BIT], 3'b000, 1'b1,
					fuse_image[`SH_ADDR_LSB +: 3]};
			end else if (addr_cfg_wr_done && (pend_ff || addr_cfg_wr_en)) begin
				addr_cfg_ff <= addr_cfg_wr_en ? addr_cfg_wr_data : addr_pend_ff;
				pend_ff <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------------
	assign bus_address_config = {addr_cfg_ff[7:4], 1'b1, addr_cfg_ff[2:0]};
	assign bus_target_address = addr_cfg_ff[`ADDR_USE_DEF_BIT] ? `BUS_ADDR_DEFAULT
		: {3'b000, 1'b1, addr_cfg_ff[2:0]};
	assign shadow_config_regs = shadow_ff;
	assign live_buck1_voltage = volt_ff;
	assign reg_enable = enable_ff;
	assign power_good_reset_n = pg_ff;
	assign sequence_done = (state_ff == ST_ON);
	assign device_on = (state_ff != ST_OFF);
	assign cold_loaded = cold_loaded_ff;
endmodule

//--- otp_defs.vh
// Constants for the fused-configuration loader and start-up sequencer.
// Contract
// - Power up copies fused settings into shadow registers; regulators start from shadow.
// - Trial mode skips fuse copy, starts from shadow; an outside controller starts it.
// - During power up each shadow setting is copied into its live control register. The code copies only the buck1 voltage and ramp select.
// - Shadow writes never move outputs; live register writes do. The code reads slot codes, period select and sense select straight from shadow.
// - Three-bit and four-bit slot codes; code n enables n slot periods after turn-on.
// - Code zero stays off during start-up; bus enable allowed only afterwards.
// - Slot period is 500 us when select is 0, 2000 us when 1.
// - Sequence ends at highest used slot; empty later slots add nothing.
// - Power-good reset output releases high 2.0 ms after last used slot.
// - Sense select 0: power-on input high turns on, low turns off.
// - Sense select 1: falling edge turns on; low for 4.0 s turns off.
// - Bus target address is 0x08..0x0F: bit 3 one, low bits from field.
// - New target address applies once the address-register write completes.
// - Address register bit 7 set keeps default target address 0x08.
// - Cold-start fuse load waits until supply is above undervoltage threshold.
// - Every turn-on event reloads shadow registers from fuses before sequencing. A trial start in the code skips the reload.
// - All slot timing derives from the 32 kHz timebase.
`ifndef OTP_DEFS_VH
`define OTP_DEFS_VH

// ----------------------------------------------------------------------------
// Clock and timebase
// ----------------------------------------------------------------------------
`define CLK_HZ 200000000
`define CLK_MHZ 200
`define TICK_HZ 32000
`define TICK_DIV (`CLK_HZ / `TICK_HZ)

// ----------------------------------------------------------------------------
// Timing figures and derived counts
// ----------------------------------------------------------------------------
`define SLOT_SHORT_US 500
`define SLOT_LONG_US 2000
`define PG_DELAY_US 2000
`define OFF_HOLD_MS 4000
`define RAMP_FAST_NS 2000
`define RAMP_SLOW_NS 4000
`define SLOT_SHORT_TICKS (`SLOT_SHORT_US * `TICK_HZ / 1000000)
`define SLOT_LONG_TICKS (`SLOT_LONG_US * `TICK_HZ / 1000000)
`define PG_DELAY_TICKS (`PG_DELAY_US * `TICK_HZ / 1000000)
`define OFF_HOLD_TICKS (`OFF_HOLD_MS * `TICK_HZ / 1000)
`define RAMP_FAST_CYC (`RAMP_FAST_NS * `CLK_MHZ / 1000)
`define RAMP_SLOW_CYC (`RAMP_SLOW_NS * `CLK_MHZ / 1000)

// ----------------------------------------------------------------------------
// Shadow image layout (fuse image has the same layout)
// ----------------------------------------------------------------------------
`define SH_W 43
`define SH_VOLT_LSB 0
`define SH_VOLT_W 5
`define SH_SEQ3_LSB 5
`define SH_SEQ4_LSB 20
`define SH_PERIOD_BIT 36
`define SH_RAMP_BIT 37
`define SH_SENSE_BIT 38
`define SH_ADDR_LSB 39
`define SH_USE_DEF_BIT 42
`define NUM_SEQ3 5
`define NUM_REG 9

// ----------------------------------------------------------------------------
// Bus address configuration register
// ----------------------------------------------------------------------------
`define ADDR_USE_DEF_BIT 7
`define ADDR_FIXED_BIT 3
`define ADDR_RESET 8'h08
`define BUS_ADDR_DEFAULT 7'h08

`endif

//--- tick_divider.v
// Counter that emits a one-cycle enable pulse once per programmable period.
`timescale 1ns/10ps
module tick_divider #(
	parameter W = 13
) (
	input wire core_clk,
	input wire reset_n,
	input wire clear,
	input wire [W-1:0] period,
	output reg tick_ff
);
	reg [W-1:0] cnt_ff;

	// --------------------------------------------------------------------
	// Divider
	// --------------------------------------------------------------------
	// Clear restarts the phase so the first pulse lands one full period later.
	// A period that shrinks below the running count ends the period at once,
	// so the counter never wraps through its whole range.
	always @(posedge core_clk) begin
		if (!reset_n || clear) begin
			cnt_ff <= {W{1'b0}};
			tick_ff <= 1'b0;
		end else if (cnt_ff >= period - {{(W-1){1'b0}}, 1'b1}) begin
			cnt_ff <= {W{1'b0}};
			tick_ff <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
			tick_ff <= 1'b0;
		end
	end
endmodule

//--- power_on_detect.v
// Interprets the power-on input as a level or as a push button.
`timescale 1ns/10ps
`include "otp_defs.vh"
module power_on_detect #(
	parameter HOLD_W = 17,
	parameter HOLD_TICKS = `OFF_HOLD_TICKS
) (
	input wire core_clk,
	input wire reset_n,
	input wire power_on_in,
	input wire sense_edge,
	input wire tick32,
	output reg turn_on_ff,
	output reg turn_off_ff
);
	reg prev_ff;
	reg [HOLD_W-1:0] hold_ff;
	reg held_ff;

	// --------------------------------------------------------------------
	// Turn-on and turn-off requests
	// --------------------------------------------------------------------
	// The hold timer counts slow ticks, so a press shorter than one tick
	// never contributes; the off request fires once per continuous hold.
	// One extra tick is counted so an unaligned first tick never shortens the hold.
	always @(posedge core_clk) begin
		if (!reset_n) begin
			prev_ff <= 1'b0;
			hold_ff <= {HOLD_W{1'b0}};
			held_ff <= 1'b0;
			turn_on_ff <= 1'b0;
			turn_off_ff <= 1'b0;
		end else begin
			prev_ff <= power_on_in;
			if (!sense_edge) begin
				turn_on_ff <= power_on_in;
				turn_off_ff <= !power_on_in;
				hold_ff <= {HOLD_W{1'b0}};
				held_ff <= 1'b0;
			end else begin
				turn_on_ff <= prev_ff && !power_on_in;
				turn_off_ff <= 1'b0;
				if (power_on_in) begin
					hold_ff <= {HOLD_W{1'b0}};
					held_ff <= 1'b0;
				end else if (tick32 && !held_ff) begin
					if (hold_ff == HOLD_TICKS) begin
						held_ff <= 1'b1;
						turn_off_ff <= 1'b1;
					end else begin
						hold_ff <= hold_ff + {{(HOLD_W-1){1'b0}}, 1'b1};
					end
				end
			end
		end
	end
endmodule

//--- otp_seq_chk.sv
// Port-level assertions for the start-up sequencer.
`timescale 1ns/10ps
module otp_seq_chk (
	input wire core_clk,
	input wire reset_n,
	input wire shadow_wr_en,
	input wire live_volt_wr_en,
	input wire [4:0] live_volt_wr_data,
	input wire live_en_wr_en,
	input wire [8:0] live_en_wr_data,
	input wire addr_cfg_wr_en,
	input wire [7:0] addr_cfg_wr_data,
	input wire addr_cfg_wr_done,
	input wire [42:0] shadow_config_regs,
	input wire [4:0] live_buck1_voltage,
	input wire [8:0] reg_enable,
	input wire power_good_reset_n,
	input wire sequence_done,
	input wire device_on,
	input wire [7:0] bus_address_config,
	input wire [6:0] bus_target_address
);
	// ---
	// Properties
	// ---
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	chk_zero_off: assert property (device_on && !sequence_done
		&& shadow_config_regs[7:5] == 3'h0 |-> !reg_enable[0]) else $error("zero code enabled");
	chk_pg_held: assert property (device_on && !sequence_done |-> !power_good_reset_n)
		else $error("release during sequence");
	chk_pg_rise: assert property ($rose(power_good_reset_n) |-> sequence_done)
		else $error("release before sequence end");
	chk_off_clear: assert property (!device_on && !$past(device_on)
		|-> reg_enable == 9'h000 && !power_good_reset_n) else $error("outputs live when off");
	chk_addr_fixed: assert property (bus_address_config[3]
		&& bus_target_address == (bus_address_config[7] ? 7'h08
		: {4'h1, bus_address_config[2:0]})) else $error("address outside range");
	chk_addr_apply: assert property (addr_cfg_wr_en && addr_cfg_wr_done |=>
		bus_target_address == ($past(addr_cfg_wr_data[7]) ? 7'h08
		: {4'h1, $past(addr_cfg_wr_data[2:0])})) else $error("address not applied");
	chk_shadow_inert: assert property (sequence_done && shadow_wr_en && !live_volt_wr_en
		|=> $stable(live_buck1_voltage)) else $error("shadow write moved output");
	chk_live_write: assert property (sequence_done && live_volt_wr_en |=>
		live_buck1_voltage == $past(live_volt_wr_data)) else $error("live write lost");
	chk_bus_enable: assert property (sequence_done && live_en_wr_en |=>
		reg_enable == $past(live_en_wr_data)) else $error("enable write lost");
endmodule
bind otp_startup_sequencer otp_seq_chk i_otp_seq_chk (.core_clk, .reset_n, .shadow_wr_en,
	.live_volt_wr_en, .live_volt_wr_data, .live_en_wr_en, .live_en_wr_data, .addr_cfg_wr_en,
	.addr_cfg_wr_data, .addr_cfg_wr_done, .shadow_config_regs, .live_buck1_voltage,
	.reg_enable, .power_good_reset_n, .sequence_done, .device_on, .bus_address_config,
	.bus_target_address);

//--- reg_host_model.sv
// Regulator bank and host that time-stamp each enable after a turn-on.
`timescale 1ns/10ps
module reg_host_model (
	input wire core_clk,
	input wire [8:0] reg_enable,
	input wire power_good_reset_n,
	input wire device_on,
	output int rise_at [10]
);
	wire [9:0] lines = {power_good_reset_n, reg_enable};
	int cyc = 0;
	int t0 = 0;
	logic was_on = 1'b0;
	logic [9:0] seen = 10'h000;
	// A turn-on restarts the stamps; the host leaves reset on the last line.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		was_on <= device_on;
		if (device_on && !was_on) begin
			t0 <= cyc;
			seen <= 10'h000;
		end else begin
			for (int i = 0; i < 10; i++)
				if (lines[i] && !seen[i]) begin
					rise_at[i] <= cyc - t0;
					seen[i] <= 1'b1;
				end
		end
	end
endmodule

//--- test_otp_startup_sequencer.sv
// Self-checking bench for the fused-configuration start-up sequencer.
`timescale 1ns/10ps
module test_otp_startup_sequencer;
	// ---
	// Stimulus, design and model
	// ---
	localparam int TD = 4;
	localparam int PG = 64 * TD;
	typedef struct packed {
		logic [35:0] codes;
		logic per;
		logic ramp;
		logic [8:0] en;
		logic [3:0] last;
	} row_t;
	row_t rows [3] = '{'{36'h180f03721, 1'b0, 1'b0, 9'h1af, 4'hf},
		'{36'h200000002, 1'b1, 1'b1, 9'h101, 4'h2}, '{36'h0, 1'b0, 1'b0, 9'h000, 4'h0}};
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic vin_above_threshold = 1'b0;
	logic power_on_in = 1'b0;
	logic trial_start = 1'b0;
	logic [42:0] fuse_image = 43'h0;
	logic shadow_wr_en = 1'b0;
	logic [42:0] shadow_wr_data = 43'h0;
	logic live_volt_wr_en = 1'b0;
	logic [4:0] live_volt_wr_data = 5'h00;
	logic live_en_wr_en = 1'b0;
	logic [8:0] live_en_wr_data = 9'h000;
	logic addr_cfg_wr_en = 1'b0;
	logic [7:0] addr_cfg_wr_data = 8'h00;
	logic addr_cfg_wr_done = 1'b0;
	wire [42:0] shadow_config_regs;
	wire [4:0] live_buck1_voltage;
	wire [8:0] reg_enable;
	wire buck_ramp_step, power_good_reset_n, sequence_done, device_on, cold_loaded;
	wire [7:0] bus_address_config;
	wire [6:0] bus_target_address;
	int rise_at [10];
	int miscompares = 0;
	int checks = 0;
	logic [42:0] tv = {1'b0, 3'h0, 1'b1, 2'b00, 16'h0, 15'h0008, 5'h15};
	otp_startup_sequencer #(.TICK_DIV(TD), .OFF_HOLD_TICKS(5)) i_otp_startup_sequencer (
		.core_clk, .reset_n, .vin_above_threshold, .power_on_in, .trial_start, .fuse_image,
		.shadow_wr_en, .shadow_wr_data, .live_volt_wr_en, .live_volt_wr_data, .live_en_wr_en,
		.live_en_wr_data, .addr_cfg_wr_en, .addr_cfg_wr_data, .addr_cfg_wr_done,
		.shadow_config_regs, .live_buck1_voltage, .reg_enable, .buck_ramp_step,
		.power_good_reset_n, .sequence_done, .device_on, .cold_loaded, .bus_address_config,
		.bus_target_address);
	reg_host_model i_reg_host_model (.core_clk, .reg_enable, .power_good_reset_n, .device_on,
		.rise_at);
	// The core clock runs at 200 MHz.
	always #2.5 core_clk = ~core_clk;
	// ---
	// Shared tasks
	// ---
	task automatic close_out();
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cmpv(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmpt(input string what, input int exp, input int got, input int tol);
		checks++;
		if (got < exp - tol || got > exp + tol) begin
			miscompares++;
			$display("[FAIL] %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: return power_good_reset_n;
			1: return device_on;
			2: return buck_ramp_step;
			default: return cold_loaded;
		endcase
	endfunction
	// Bounded wait; running out of cycles ends the run as a mismatch.
	task automatic wt(input int s, input logic lvl, input int lim);
		int n;
		n = 0;
		while (pick(s) !== lvl && n < lim) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= lim) begin
			miscompares++;
			$display("[FAIL] wait %0d expected %b seen timeout", s, lvl);
			close_out();
		end
	endtask
	// A strobe is one cycle wide; the trailing cycle lets the stored value show.
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge core_clk);
		s = 1'b0;
		@(negedge core_clk);
	endtask
	function automatic logic [42:0] mk(input row_t r);
		logic [42:0] v;
		v = {5'h00, r.ramp, r.per, 31'h0, 5'h0b};
		for (int i = 0; i < 5; i++)
			v[5 + 3 * i +: 3] = r.codes[4 * i +: 3];
		for (int j = 0; j < 4; j++)
			v[20 + 4 * j +: 4] = r.codes[20 + 4 * j +: 4];
		return v;
	endfunction
	// One level-mode power-up from fuses; request, load and copy take three cycles.
	task automatic run(input row_t r);
		int p;
		int off;
		int tol;
		int e;
		p = r.per ? 64 * TD : 16 * TD;
		power_on_in = 1'b0;
		wt(1, 1'b0, 20);
		cmpv("off enables", 9'h000, reg_enable);
		fuse_image = mk(r);
		@(negedge core_clk);
		power_on_in = 1'b1;
		wt(0, 1'b1, 5000);
		@(negedge core_clk);
		cmpv("shadow", mk(r), shadow_config_regs);
		cmpv("enables", r.en, reg_enable);
		cmpv("live volt", 5'h0b, live_buck1_voltage);
		cmpv("done", 1'b1, sequence_done);
		off = 3;
		tol = 1;
		for (int i = 0; i < 9; i++)
			if (r.en[i])
				cmpt("slot", r.codes[4 * i +: 4] * p + off, rise_at[i], tol);
		cmpt("release", r.last * p + PG + off, rise_at[9], tol);
		wt(2, 1'b1, 900);
		@(negedge core_clk);
		e = 1;
		while (buck_ramp_step !== 1'b1 && e < 900) begin
			@(negedge core_clk);
			e++;
		end
		cmpt("ramp gap", r.ramp ? 800 : 400, e, 0);
	endtask
	// ---
	// Main sequence
	// ---
	initial begin
		repeat (6) @(negedge core_clk);
		reset_n = 1'b1;
		@(negedge core_clk);
		cmpv("reset enables", 9'h000, reg_enable);
		cmpv("reset config", 8'h08, bus_address_config);
		fuse_image = mk(rows[2]);
		repeat (10) @(negedge core_clk);
		cmpv("cold load", 1'b0, cold_loaded);
		vin_above_threshold = 1'b1;
		wt(3, 1'b1, 10);
		cmpv("cold shadow", fuse_image, shadow_config_regs);
		foreach (rows[k])
			run(rows[k]);
		// Trial start from a written shadow image in push-button mode.
		power_on_in = 1'b0;
		wt(1, 1'b0, 20);
		shadow_wr_data = tv;
		pulse(shadow_wr_en);
		power_on_in = 1'b1;
		pulse(trial_start);
		wt(0, 1'b1, 5000);
		cmpv("trial shadow", tv, shadow_config_regs);
		cmpv("trial enables", 9'h002, reg_enable);
		cmpv("trial volt", 5'h15, live_buck1_voltage);
		shadow_wr_data = tv ^ 43'h1f;
		pulse(shadow_wr_en);
		cmpv("volt kept", 5'h15, live_buck1_voltage);
		live_volt_wr_data = 5'h07;
		pulse(live_volt_wr_en);
		cmpv("volt set", 5'h07, live_buck1_voltage);
		live_en_wr_data = 9'h1ff;
		pulse(live_en_wr_en);
		cmpv("bus enable", 9'h1ff, reg_enable);
		// A long low turns off; a short low turns on again and reloads the fuses.
		power_on_in = 1'b0;
		repeat (10) @(negedge core_clk);
		cmpv("held on", 1'b1, device_on);
		wt(1, 1'b0, 40);
		cmpv("off enables", 9'h000, reg_enable);
		fuse_image = mk(rows[2]) | 43'h4000000000;
		power_on_in = 1'b1;
		repeat (3) @(negedge core_clk);
		power_on_in = 1'b0;
		repeat (2) @(negedge core_clk);
		power_on_in = 1'b1;
		wt(0, 1'b1, 5000);
		cmpv("reload", fuse_image, shadow_config_regs);
		// Every address field, a delayed completion, then the default override.
		addr_cfg_wr_en = 1'b1;
		addr_cfg_wr_done = 1'b1;
		for (int f = 0; f < 8; f++) begin
			addr_cfg_wr_data = 8'(f);
			@(negedge core_clk);
			cmpv("target", {4'h1, f[2:0]}, bus_target_address);
		end
		addr_cfg_wr_done = 1'b0;
		addr_cfg_wr_data = 8'h05;
		@(negedge core_clk);
		addr_cfg_wr_en = 1'b0;
		@(negedge core_clk);
		cmpv("target held", 7'h0f, bus_target_address);
		pulse(addr_cfg_wr_done);
		cmpv("target moved", 7'h0d, bus_target_address);
		addr_cfg_wr_data = 8'h85;
		addr_cfg_wr_done = 1'b1;
		pulse(addr_cfg_wr_en);
		addr_cfg_wr_done = 1'b0;
		cmpv("default target", 7'h08, bus_target_address);
		cmpv("config", 8'h8d, bus_address_config);
		close_out();
	end
endmodule
